//--- rtl/cmpri_top.sv
// Purpose: register file and interrupt logic of the comparator reference block
// Assumes: raw comparator result arrives synchronous to CLOCK_I
// Notes: no write strobe splitting below 16 bits beyond byte lanes
// Notes: hardware flag sets win over any clear in the same cycle
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module cmpri_top (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic CE_I, // clock enable, freezes all state when low
  input wire logic RAW_CMP_I, // raw comparator decision
  input wire logic [31:0] S_AWADDR_I,
  input wire logic S_AWVALID_I,
  output logic S_AWREADY_O,
  input wire logic [31:0] S_WDATA_I,
  input wire logic [3:0] S_WSTRB_I,
  input wire logic S_WVALID_I,
  output logic S_WREADY_O,
  output logic [1:0] S_BRESP_O,
  output logic S_BVALID_O,
  input wire logic S_BREADY_I,
  input wire logic [31:0] S_ARADDR_I,
  input wire logic S_ARVALID_I,
  output logic S_ARREADY_O,
  output logic [31:0] S_RDATA_O,
  output logic [1:0] S_RRESP_O,
  output logic S_RVALID_O,
  input wire logic S_RREADY_I,
  output cmpri_pkg::cmpri_analog_t ANALOG_O,
  output logic [15:0] INPUT_BUFFER_DISABLE_O,
  output logic COMPARATOR_OUTPUT_O,
  output logic IRQ_O
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] ref_ctrl_q; // reference_control
  logic [15:0] port_dis_q; // port_buffer_disable
  logic [15:0] irq_ctrl_q; // irq_control, only mask bits live
  logic [1:0] link_ctrl_q; // exchange and edge select
  logic cmp_out_q; // comparator_output after exchange
  // write channel holding registers
  logic aw_have_q; // write address captured
  logic w_have_q; // write data captured
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [15:0] vector_d; // current vector word

  // ----------------------------------------------------------------
  // decoded fields and per-cycle strobes
  // ----------------------------------------------------------------
  // named views keep the bit positions in the package
  logic input_exchange;
  logic irq_edge_select;
  logic output_irq_enable;
  logic inverted_irq_enable;
  logic output_irq_flag;
  logic inverted_irq_flag;
  logic cmp_out_d;
  logic rise;
  logic fall;
  logic set_ifg;
  logic set_iifg;
  logic do_write;
  logic do_read;
  logic [15:0] wr16;
  logic clr_ifg_by_read;
  logic clr_iifg_by_read;
  logic [15:0] irq_wr_val;

  // field views of the stored registers
  assign input_exchange = link_ctrl_q[cmpri_pkg::CMPRI_EX_BIT];
  assign irq_edge_select = link_ctrl_q[cmpri_pkg::CMPRI_IES_BIT];
  assign output_irq_enable = irq_ctrl_q[cmpri_pkg::CMPRI_IE_BIT];
  assign inverted_irq_enable = irq_ctrl_q[cmpri_pkg::CMPRI_IIE_BIT];
  assign output_irq_flag = irq_ctrl_q[cmpri_pkg::CMPRI_IFG_BIT];
  assign inverted_irq_flag = irq_ctrl_q[cmpri_pkg::CMPRI_IIFG_BIT];

  // ----------------------------------------------------------------
  // comparator output and edges
  // ----------------------------------------------------------------
  // exchange inverts the output seen by software and edge logic
  assign cmp_out_d = RAW_CMP_I ^ input_exchange; // [RQ16]
  // edges compare this cycle's output against last cycle's
  assign rise = cmp_out_d & ~cmp_out_q;
  assign fall = ~cmp_out_d & cmp_out_q;
  // edge select chooses which transition feeds which flag
  assign set_ifg = irq_edge_select ? fall : rise; // [RQ9] [RQ13]
  assign set_iifg = irq_edge_select ? rise : fall; // [RQ9] [RQ13]

  // reset low matches an idle low input, so no false edge follows
  // frozen with the rest of the state while the enable is low
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cmp_out_q <= 1'b0;
    end else if (CE_I) begin
      cmp_out_q <= cmp_out_d;
    end
  end

  // ----------------------------------------------------------------
  // vector word
  // ----------------------------------------------------------------
  // only enabled flags show; normal flag wins priority
  // a read clears only the flag behind the code it returns
  always_comb begin
    if (output_irq_flag && output_irq_enable) begin
      vector_d = cmpri_pkg::CMPRI_VEC_OUT; // [RQ14] [RQ15]
    end else if (inverted_irq_flag && inverted_irq_enable) begin
      vector_d = cmpri_pkg::CMPRI_VEC_INV; // [RQ15]
    end else begin
      vector_d = cmpri_pkg::CMPRI_VEC_NONE; // [RQ15]
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign do_write = aw_have_q && w_have_q && !S_BVALID_O;
  // a write lands once both halves are held, and only once,
  // since the pending answer blocks a repeat
  // 16-bit registers sit in the low half; upper lanes are ignored
  assign wr16 = {wstrb_q[1] ? wdata_q[15:8] : 8'h00, wstrb_q[0] ? wdata_q[7:0] : 8'h00};

  // address and data accepted independently, in either order
  // readies pulse every other cycle while idle: legal, and it
  // keeps a held transfer from being taken twice
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      S_AWREADY_O <= 1'b0;
      S_WREADY_O <= 1'b0;
      S_BVALID_O <= 1'b0;
      S_BRESP_O <= cmpri_pkg::CMPRI_RESP_OKAY;
    end else if (CE_I) begin
      // default: offer ready again once the slot is free
      S_AWREADY_O <= !aw_have_q && !S_AWREADY_O;
      S_WREADY_O <= !w_have_q && !S_WREADY_O;
      if (S_AWVALID_I && S_AWREADY_O) begin
        aw_have_q <= 1'b1;
        awaddr_q <= S_AWADDR_I;
        S_AWREADY_O <= 1'b0;
      end
      if (S_WVALID_I && S_WREADY_O) begin
        w_have_q <= 1'b1;
        wdata_q <= S_WDATA_I;
        wstrb_q <= S_WSTRB_I;
        S_WREADY_O <= 1'b0;
      end
      // answer okay for mapped aligned words, error otherwise
      if (do_write) begin
        S_BVALID_O <= 1'b1;
        S_BRESP_O <= (awaddr_q[31:5] == 27'h0 && awaddr_q[1:0] == 2'h0 &&
                      awaddr_q[4:0] <= cmpri_pkg::CMPRI_OFF_LINK_CTRL) ?
                     cmpri_pkg::CMPRI_RESP_OKAY : cmpri_pkg::CMPRI_RESP_SLVERR;
      end
      // answer taken: free both slots for the next write
      if (S_BVALID_O && S_BREADY_I) begin
        S_BVALID_O <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // byte strobes merge into the held value lane by lane
  // the vector word has no storage, so writes to it vanish
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ref_ctrl_q <= cmpri_pkg::CMPRI_RST_16;
      port_dis_q <= cmpri_pkg::CMPRI_RST_16;
      link_ctrl_q <= 2'h0;
    end else if (CE_I && do_write && awaddr_q[31:5] == 27'h0) begin
      unique case (awaddr_q[4:0])
        {1'b0, cmpri_pkg::CMPRI_OFF_REF_CTRL}: ref_ctrl_q <= wr16 | (ref_ctrl_q & ~{{8{wstrb_q[1]}}, {8{wstrb_q[0]}}});
        {1'b0, cmpri_pkg::CMPRI_OFF_PORT_DIS}: port_dis_q <= wr16 | (port_dis_q & ~{{8{wstrb_q[1]}}, {8{wstrb_q[0]}}});
        cmpri_pkg::CMPRI_OFF_LINK_CTRL: if (wstrb_q[0]) link_ctrl_q <= wdata_q[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt control: enables and flags
  // ----------------------------------------------------------------
  // reserved bits are masked so they always read zero
  assign irq_wr_val = wr16 & cmpri_pkg::CMPRI_IRQ_MASK; // [RQ11]
  // read clear follows the code that the read returns
  assign clr_ifg_by_read = do_read && vector_d == cmpri_pkg::CMPRI_VEC_OUT; // [RQ14]
  assign clr_iifg_by_read = do_read && vector_d == cmpri_pkg::CMPRI_VEC_INV; // [RQ14]

  // hardware set wins over both software clear and read clear
  // order matters: write first, then read clear, then set,
  // because the last non-blocking assignment to a bit wins
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      irq_ctrl_q <= cmpri_pkg::CMPRI_RST_16;
    end else if (CE_I) begin
      if (do_write && awaddr_q[31:5] == 27'h0 && awaddr_q[4:0] == {1'b0, cmpri_pkg::CMPRI_OFF_IRQ_CTRL}) begin
        if (wstrb_q[1]) irq_ctrl_q[15:8] <= irq_wr_val[15:8]; // [RQ8] [RQ11]
        if (wstrb_q[0]) irq_ctrl_q[7:0] <= irq_wr_val[7:0]; // [RQ10] [RQ11]
      end
      if (clr_ifg_by_read) irq_ctrl_q[cmpri_pkg::CMPRI_IFG_BIT] <= 1'b0; // [RQ14]
      if (clr_iifg_by_read) irq_ctrl_q[cmpri_pkg::CMPRI_IIFG_BIT] <= 1'b0; // [RQ14]
      if (set_ifg) irq_ctrl_q[cmpri_pkg::CMPRI_IFG_BIT] <= 1'b1; // [RQ9]
      if (set_iifg) irq_ctrl_q[cmpri_pkg::CMPRI_IIFG_BIT] <= 1'b1; // [RQ9]
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  // only a read of the vector word has a side effect
  assign do_read = S_ARVALID_I && S_ARREADY_O && S_ARADDR_I[31:5] == 27'h0 &&
                   S_ARADDR_I[4:0] == {1'b0, cmpri_pkg::CMPRI_OFF_IRQ_VEC};

  // one read at a time; answer one cycle after address is taken
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      S_ARREADY_O <= 1'b0;
      S_RVALID_O <= 1'b0;
      S_RDATA_O <= 32'h0000_0000;
      S_RRESP_O <= cmpri_pkg::CMPRI_RESP_OKAY;
    end else if (CE_I) begin
      S_ARREADY_O <= !S_RVALID_O && !S_ARREADY_O;
      // address taken: decode and load the answer
      if (S_ARVALID_I && S_ARREADY_O) begin
        S_ARREADY_O <= 1'b0;
        S_RVALID_O <= 1'b1;
        S_RRESP_O <= cmpri_pkg::CMPRI_RESP_OKAY;
        if (S_ARADDR_I[31:5] != 27'h0 || S_ARADDR_I[1:0] != 2'h0) begin
          S_RDATA_O <= 32'h0000_0000;
          S_RRESP_O <= cmpri_pkg::CMPRI_RESP_SLVERR;
        end else begin
          // unused words inside the map answer with an error
          unique case (S_ARADDR_I[4:0])
            {1'b0, cmpri_pkg::CMPRI_OFF_REF_CTRL}: S_RDATA_O <= {16'h0000, ref_ctrl_q};
            {1'b0, cmpri_pkg::CMPRI_OFF_PORT_DIS}: S_RDATA_O <= {16'h0000, port_dis_q};
            {1'b0, cmpri_pkg::CMPRI_OFF_IRQ_CTRL}: S_RDATA_O <= {16'h0000, irq_ctrl_q}; // [RQ11]
            {1'b0, cmpri_pkg::CMPRI_OFF_IRQ_VEC}: S_RDATA_O <= {16'h0000, vector_d}; // [RQ12]
            cmpri_pkg::CMPRI_OFF_LINK_CTRL: S_RDATA_O <= {29'h0, cmp_out_q, link_ctrl_q};
            default: begin
              S_RDATA_O <= 32'h0000_0000;
              S_RRESP_O <= cmpri_pkg::CMPRI_RESP_SLVERR;
            end
          endcase
        end
      end
      // answer taken: ready returns one cycle later
      if (S_RVALID_O && S_RREADY_I) begin
        S_RVALID_O <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // analog steering outputs
  // ----------------------------------------------------------------
  // registered so outputs come straight from flip-flops
  // one cycle of lag behind the registers is accepted for that
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      // every steering line starts in its off state
      ANALOG_O <= '0;
      INPUT_BUFFER_DISABLE_O <= 16'h0000;
      COMPARATOR_OUTPUT_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else if (CE_I) begin
      ANALOG_O.clocked_mode <= ref_ctrl_q[cmpri_pkg::CMPRI_ACC_BIT]; // [RQ1]
      ANALOG_O.ref_level <= ref_ctrl_q[cmpri_pkg::CMPRI_LVL_HI:cmpri_pkg::CMPRI_LVL_LO]; // [RQ2]
      ANALOG_O.ref_request <= ref_ctrl_q[cmpri_pkg::CMPRI_LVL_HI:cmpri_pkg::CMPRI_LVL_LO]
                              != cmpri_pkg::CMPRI_LVL_OFF; // [RQ1] [RQ2]
      // tap follows the stored output, as the ladder sees it
      ANALOG_O.active_tap <= cmp_out_q ? ref_ctrl_q[cmpri_pkg::CMPRI_TAP1_HI:cmpri_pkg::CMPRI_TAP1_LO]  // [RQ3]
                                       : ref_ctrl_q[cmpri_pkg::CMPRI_TAP0_HI:cmpri_pkg::CMPRI_TAP0_LO]; // [RQ4]
      // source code off leaves every reference path unpowered
      ANALOG_O.ladder_on <= ref_ctrl_q[cmpri_pkg::CMPRI_SRC_HI:cmpri_pkg::CMPRI_SRC_LO] == cmpri_pkg::CMPRI_SRC_VCC ||
                            ref_ctrl_q[cmpri_pkg::CMPRI_SRC_HI:cmpri_pkg::CMPRI_SRC_LO] == cmpri_pkg::CMPRI_SRC_SHL; // [RQ5]
      ANALOG_O.ladder_from_shared <= ref_ctrl_q[cmpri_pkg::CMPRI_SRC_HI:cmpri_pkg::CMPRI_SRC_LO]
                                     == cmpri_pkg::CMPRI_SRC_SHL; // [RQ5]
      ANALOG_O.direct_ref <= ref_ctrl_q[cmpri_pkg::CMPRI_SRC_HI:cmpri_pkg::CMPRI_SRC_LO]
                             == cmpri_pkg::CMPRI_SRC_DIR; // [RQ5]
      ANALOG_O.ref_on_minus <= ref_ctrl_q[cmpri_pkg::CMPRI_TERM_BIT] ^ input_exchange; // [RQ6]
      ANALOG_O.swap_inputs <= input_exchange; // [RQ16]
      // one bit per channel, passed straight through
      INPUT_BUFFER_DISABLE_O <= port_dis_q; // [RQ7]
      // same value the edge logic stores, so software and flags agree
      COMPARATOR_OUTPUT_O <= cmp_out_d;
      // request follows enabled pending flags, including this cycle's edges
      // a flag cleared by this cycle's read does not hold it up
      IRQ_O <= (vector_d != cmpri_pkg::CMPRI_VEC_NONE && !clr_ifg_by_read && !clr_iifg_by_read) ||
               ((set_ifg | (output_irq_flag & ~clr_ifg_by_read)) & output_irq_enable) ||
               ((set_iifg | (inverted_irq_flag & ~clr_iifg_by_read)) & inverted_irq_enable); // [RQ17]
    end
  end

endmodule : cmpri_top

//--- rtl/cmpri_pkg.sv
// Purpose: constants, register map and carrier types for the comparator reference and interrupt registers
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register
// Notes: register offsets are byte addresses
//
// Summary of operation
// (RQ1) accuracy bit 15: static or clocked mode
// (RQ2) level 00 off, else request level
// (RQ3) output high selects upper tap code
// (RQ4) output low selects lower tap code
// (RQ5) source field picks ladder supply routing
// (RQ6) terminal bit picks plus/minus, exchange swaps
// (RQ7) sixteen bits disable channel input buffers
// (RQ8) enable bits 9 and 8 gate interrupts
// (RQ9) output edges set the two flags
// (RQ10) software may write flags either way
// (RQ11) reserved control bits read zero
// (RQ12) vector word is read only
// (RQ13) edge select swaps rising/falling flag edges
// (RQ14) vector shows enabled flags; read clears highest
// (RQ15) vector codes 00, 02 normal, 04 inverted
// (RQ16) exchange swaps inputs and inverts output
// (RQ17) request high while enabled flag pending
package cmpri_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CMPRI_OFF_REF_CTRL = 4'h0; // reference_control
  localparam logic [3:0] CMPRI_OFF_PORT_DIS = 4'h4; // port_buffer_disable
  localparam logic [3:0] CMPRI_OFF_IRQ_CTRL = 4'h8; // irq_control
  localparam logic [3:0] CMPRI_OFF_IRQ_VEC = 4'hc; // irq_vector_word
  localparam logic [4:0] CMPRI_OFF_LINK_CTRL = 5'h10; // exchange and edge select

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] CMPRI_RST_16 = 16'h0000;
  localparam int CMPRI_ACC_BIT = 15;
  localparam int CMPRI_LVL_HI = 14;
  localparam int CMPRI_LVL_LO = 13;
  localparam int CMPRI_TAP1_HI = 12;
  localparam int CMPRI_TAP1_LO = 8;
  localparam int CMPRI_SRC_HI = 7;
  localparam int CMPRI_SRC_LO = 6;
  localparam int CMPRI_TERM_BIT = 5;
  localparam int CMPRI_TAP0_HI = 4;
  localparam int CMPRI_TAP0_LO = 0;
  localparam int CMPRI_IIE_BIT = 9;
  localparam int CMPRI_IE_BIT = 8;
  localparam int CMPRI_IIFG_BIT = 1;
  localparam int CMPRI_IFG_BIT = 0;
  localparam int CMPRI_EX_BIT = 0; // link control: input exchange
  localparam int CMPRI_IES_BIT = 1; // link control: edge select
  localparam logic [15:0] CMPRI_IRQ_MASK = 16'h0303; // writable irq bits

  // ----------------------------------------------------------------
  // vector codes and field encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] CMPRI_VEC_NONE = 16'h0000;
  localparam logic [15:0] CMPRI_VEC_OUT = 16'h0002;
  localparam logic [15:0] CMPRI_VEC_INV = 16'h0004;
  localparam logic [1:0] CMPRI_LVL_OFF = 2'h0;
  localparam logic [1:0] CMPRI_SRC_OFF = 2'h0;
  localparam logic [1:0] CMPRI_SRC_VCC = 2'h1;
  localparam logic [1:0] CMPRI_SRC_SHL = 2'h2;
  localparam logic [1:0] CMPRI_SRC_DIR = 2'h3;
  localparam logic [1:0] CMPRI_RESP_OKAY = 2'h0;
  localparam logic [1:0] CMPRI_RESP_SLVERR = 2'h2;

  // analog steering bundle
  typedef struct packed {
    logic ref_request; // shared reference wanted
    logic [1:0] ref_level; // requested level code
    logic clocked_mode; // low-power clocked reference
    logic ladder_on; // resistor ladder powered
    logic ladder_from_shared; // ladder fed by shared ref
    logic direct_ref; // shared ref straight to terminal
    logic ref_on_minus; // reference on minus terminal
    logic swap_inputs; // inputs exchanged
    logic [4:0] active_tap; // resistor tap in use
  } cmpri_analog_t;

endpackage : cmpri_pkg

//--- test/cmpri_chk.sv
// Purpose: port-level checks of the comparator reference and interrupt registers
// Assumes: bound to every cmpri_top instance, one clock domain
// Notes: only relations visible at the top ports are checked
`timescale 1ns/1ps
module cmpri_chk (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic [31:0] S_ARADDR_I,
  input wire logic S_ARVALID_I,
  input wire logic S_ARREADY_O,
  input wire logic [31:0] S_RDATA_O,
  input wire logic S_RVALID_O,
  input wire logic S_RREADY_I,
  input wire logic [1:0] S_BRESP_O,
  input wire logic S_BVALID_O,
  input wire logic S_BREADY_I,
  input wire cmpri_pkg::cmpri_analog_t ANALOG_O,
  input wire logic [15:0] INPUT_BUFFER_DISABLE_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  // ---------------------------------------------------------------
  // read address tracker: rdata only means something per address
  // ---------------------------------------------------------------
  logic [31:0] rd_addr_q; // address of the read now answered
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rd_addr_q <= 32'h0;
    end else if (S_ARVALID_I && S_ARREADY_O) begin
      rd_addr_q <= S_ARADDR_I;
    end
  end
  a_req_level: assert property (ANALOG_O.ref_request == (ANALOG_O.ref_level != 2'h0))
    else $error("reference request disagrees with level");
  a_direct_alone: assert property (ANALOG_O.direct_ref |-> !ANALOG_O.ladder_on && !ANALOG_O.ladder_from_shared)
    else $error("direct reference with ladder powered");
  a_shared_ladder: assert property (ANALOG_O.ladder_from_shared |-> ANALOG_O.ladder_on)
    else $error("shared feed without ladder");
  a_irqctl_rsvd: assert property (S_RVALID_O && rd_addr_q == 32'h8 |-> (S_RDATA_O & ~32'h303) == 32'h0)
    else $error("reserved irq control bits read nonzero");
  a_vec_code: assert property (S_RVALID_O && rd_addr_q == 32'hc |-> S_RDATA_O inside {32'h0, 32'h2, 32'h4})
    else $error("illegal vector code");
  a_rvalid_hold: assert property (S_RVALID_O && !S_RREADY_I |=> S_RVALID_O && $stable(S_RDATA_O))
    else $error("read answer dropped before taken");
  a_bvalid_hold: assert property (S_BVALID_O && !S_BREADY_I |=> S_BVALID_O && $stable(S_BRESP_O))
    else $error("write answer dropped before taken");
  // the disable pins may only move as a write completes
  a_buf_change: assert property ($changed(INPUT_BUFFER_DISABLE_O) |-> S_BVALID_O || $past(S_BVALID_O))
    else $error("buffer disable changed without a write");
endmodule : cmpri_chk

bind cmpri_top cmpri_chk u_chk (.CLOCK_I, .NRST_I, .S_ARADDR_I, .S_ARVALID_I, .S_ARREADY_O, .S_RDATA_O,
  .S_RVALID_O, .S_RREADY_I, .S_BRESP_O, .S_BVALID_O, .S_BREADY_I, .ANALOG_O, .INPUT_BUFFER_DISABLE_O);

//--- test/cmpri_top_tb.sv
// Purpose: self-checking bench for cmpri_top against a register model
// Assumes: AXI4-Lite master with late ready so answers must stand
// Notes: model tracks flags from comparator edges it drives itself
`timescale 1ns/1ps
module cmpri_top_tb;
  logic clk, nrst, raw, awv, wv, bready, arv, rready;
  logic [31:0] awaddr, wdata, araddr;
  logic aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, out_cmp, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] buf_dis;
  logic ce; // clock enable under bench control
  logic [3:0] strb; // write byte strobes
  cmpri_pkg::cmpri_analog_t ana;
  int num_errors, checks, ref_m, pd_m, ic_m, lk_m; // counters and register model
  cmpri_top u_dut (.CLOCK_I(clk), .NRST_I(nrst), .CE_I(ce), .RAW_CMP_I(raw), .S_AWADDR_I(awaddr),
    .S_AWVALID_I(awv), .S_AWREADY_O(aw_rdy), .S_WDATA_I(wdata), .S_WSTRB_I(strb), .S_WVALID_I(wv),
    .S_WREADY_O(w_rdy), .S_BRESP_O(bresp), .S_BVALID_O(bvalid), .S_BREADY_I(bready), .S_ARADDR_I(araddr),
    .S_ARVALID_I(arv), .S_ARREADY_O(ar_rdy), .S_RDATA_O(rdata), .S_RRESP_O(rresp), .S_RVALID_O(rvalid),
    .S_RREADY_I(rready), .ANALOG_O(ana), .INPUT_BUFFER_DISABLE_O(buf_dis), .COMPARATOR_OUTPUT_O(out_cmp),
    .IRQ_O(irq));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // compare, close, bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // ready is raised only once the answer is seen, so it must stand a cycle
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ha, hw, hb, bv;
    int n;
    n = 0;
    hb = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!hb && n < 40) begin
      #1;
      ha = awv && aw_rdy;
      hw = wv && w_rdy;
      hb = bready && bvalid;
      bv = bvalid;
      r = bresp;
      @(posedge clk);
      n++;
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      bready <= bv && !hb;
    end
    chk("wr_done", hb, 1'b1);
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ha, hr, rv;
    int n;
    n = 0;
    hr = 0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    while (!hr && n < 40) begin
      #1;
      ha = arv && ar_rdy;
      hr = rready && rvalid;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      n++;
      if (ha) arv <= 1'b0;
      rready <= rv && !hr;
    end
    chk("rd_done", hr, 1'b1);
  endtask : axi_rd
  // ---------------------------------------------------------------
  // model: flags follow edges of the output after exchange
  // ---------------------------------------------------------------
  task automatic edge_m(input bit o, input bit nw);
    if (o != nw) ic_m = ic_m | ((nw ^ lk_m[1]) ? 1 : 2);
  endtask : edge_m
  function automatic int vec_m(); // vector read clears the winner
    if (ic_m[8] && ic_m[0]) begin
      ic_m[0] = 1'b0;
      return 2;
    end else if (ic_m[9] && ic_m[1]) begin
      ic_m[1] = 1'b0;
      return 4;
    end
    return 0;
  endfunction : vec_m
  task automatic wr_m(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    logic [15:0] m;
    bit o;
    o = raw ^ lk_m[0];
    axi_wr(a, d, r);
    m = {{8{strb[1]}}, {8{strb[0]}}}; // lanes this write touched
    case (a)
      32'h0: ref_m = (d[15:0] & m) | (ref_m & ~m);
      32'h4: pd_m = (d[15:0] & m) | (pd_m & ~m);
      32'h8: ic_m = ((d[15:0] & m) | (ic_m & ~m)) & 32'h303;
      32'h10: if (strb[0]) lk_m = d & 32'h3;
      default: ;
    endcase
    edge_m(o, raw ^ lk_m[0]);
    chk("bresp", r, (a > 32'h10) ? 2'h2 : 2'h0);
    repeat (5) @(posedge clk);
    #1;
  endtask : wr_m
  task automatic rd_chk(input logic [31:0] a);
    logic [31:0] d;
    logic [1:0] r;
    int e;
    axi_rd(a, d, r);
    case (a)
      32'h0: e = ref_m;
      32'h4: e = pd_m;
      32'h8: e = ic_m;
      32'hc: e = vec_m();
      32'h10: e = lk_m | ((raw ^ lk_m[0]) ? 4 : 0);
      default: e = 0;
    endcase
    chk("rdata", d, e);
    chk("rresp", r, (a > 32'h10) ? 2'h2 : 2'h0);
    repeat (3) @(posedge clk);
    #1;
    chk("irq", irq, (ic_m[9:8] & ic_m[1:0]) != 0);
  endtask : rd_chk
  task automatic set_raw(input bit v);
    bit o;
    o = raw ^ lk_m[0];
    @(posedge clk);
    raw <= v;
    edge_m(o, v ^ lk_m[0]);
    repeat (6) @(posedge clk);
    #1;
  endtask : set_raw
  task automatic chk_ana();
    logic [15:0] e;
    bit x, co;
    e = ref_m[15:0];
    x = lk_m[0];
    co = raw ^ x;
    chk("cmp_out", out_cmp, co);
    chk("ref_req", ana.ref_request, e[14:13] != 2'h0);
    chk("ref_lvl", ana.ref_level, e[14:13]);
    chk("clk_mode", ana.clocked_mode, e[15]);
    chk("ladder", ana.ladder_on, e[7:6] == 2'h1 || e[7:6] == 2'h2);
    chk("lad_shr", ana.ladder_from_shared, e[7:6] == 2'h2);
    chk("direct", ana.direct_ref, e[7:6] == 2'h3);
    chk("minus", ana.ref_on_minus, e[5] ^ x);
    chk("swap", ana.swap_inputs, x);
    chk("tap", ana.active_tap, co ? e[12:8] : e[4:0]);
  endtask : chk_ana
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    logic [31:0] d;
    {nrst, raw, awv, wv, bready, arv, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    ce = 1'b1;
    strb = 4'hf;
    void'($urandom(83135));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a <= 32'h20; a += 4) rd_chk(a);
    wr_m(32'h20, $urandom); // unmapped write refused
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d[7:6] = i[1:0];
      d[14:13] = i[2:1];
      wr_m(32'h0, d);
      chk_ana();
      rd_chk(32'h0);
    end
    wr_m(32'h4, $urandom);
    chk("buf_dis", buf_dis, pd_m);
    rd_chk(32'h4);
    @(posedge clk);
    strb <= 4'h2; // upper lane alone: lower byte keeps its value
    wr_m(32'h4, $urandom);
    rd_chk(32'h4);
    @(posedge clk);
    strb <= 4'hf;
    wr_m(32'hc, 32'hffff);
    wr_m(32'h8, 32'hffffffff); // software sets both flags
    rd_chk(32'h8);
    repeat (3) rd_chk(32'hc);
    wr_m(32'h8, 32'h0203); // only inverted enabled
    rd_chk(32'hc);
    rd_chk(32'h8);
    wr_m(32'h0, 32'h352a);
    for (int s = 0; s < 2; s++) begin
      wr_m(32'h8, 32'h0);
      wr_m(32'h10, s << 1);
      set_raw(1'b1);
      chk_ana();
      rd_chk(32'h8);
      set_raw(1'b0);
      chk_ana();
      rd_chk(32'h8);
    end
    wr_m(32'h10, 32'h0);
    wr_m(32'h8, 32'h0100);
    wr_m(32'h10, 32'h1); // exchange alone makes an output edge
    chk_ana();
    rd_chk(32'h10);
    rd_chk(32'h8);
    wr_m(32'h10, 32'h0);
    rd_chk(32'h8);
    @(posedge clk);
    ce <= 1'b0; // frozen: an input pulse must leave no trace
    raw <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("frozen", out_cmp, 1'b0);
    @(posedge clk);
    raw <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    rd_chk(32'h8);
    report_and_stop();
  end
endmodule : cmpri_top_tb
